// [logic/dcb_sequencer.v]
// Purpose: Sequencing and supervision of a DC-injection braking unit.
// Assumes: Contact and sensor inputs are clean and synchronous.
// Notes:   Registers over APB; three-cycle access, one wait state.
//
// Behaviour
// - Close interlock after power-up when no fault is present.
// - Contact closed at power-up does not start braking.
// - Braking starts when start contact recloses after being open.
// - Interlock stays open for the whole braking interval.
// - Wait adaptive remanence delay, then pull in braking relay.
// - Wait relay bounce time, then enable braking current.
// - Current flows for set time, 0 to 30 s or 60 s.
// - Current setpoint follows setting, 10 to 100 percent.
// - Above 20 s braking time the setpoint ceiling is lowered.
// - Five braking operations in a row are tolerated.
// - Excess braking frequency latches the interlock open.
// - Indicate-only variant signals excess frequency without interlock.
// - Frequency interlock clears only by removing supply.
// - Start contact open 150 ms during braking aborts braking.
// - Restart allowed only 1200 ms after contact recloses.
// - Ready LED steady while ready without fault.
// - Ready LED flashes 2, 3 or 4 times for faults.
// - Current LED lit exactly while braking current flows.
// - Star-contactor path closed during braking.
// - Current ends only 2 s after motor standstill; without standstill the code ends it at 60 s.
// - After abort, hold interlock open until contact recloses.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "dcb_consts.vh"
module dcb_sequencer
#(
   parameter TICK_DIV = `DCB_CLK_KHZ
)
(
   // Clock and reset
   input  wire        ref_clk,
   input  wire        nrst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Motor side inputs
   input  wire        start_contact_in,
   input  wire        remanence_low,
   input  wire        motor_standstill,
   input  wire        current_reached,
   input  wire        controller_fault,
   // Relay contacts from relay_common_terminal
   output reg         interlock_terminal,
   output reg         star_contactor_terminal,
   // Power stage
   output reg         brake_relay,
   output reg         current_enable,
   output reg  [6:0]  current_setpoint,
   // Indicators
   output wire        led_ready,
   output wire        led_current
);
   localparam S_IDLE    = 3'h0;
   localparam S_REMAN   = 3'h1;
   localparam S_BOUNCE  = 3'h2;
   localparam S_BRAKE   = 3'h3;
   localparam S_ABORT   = 3'h4;
   localparam S_RESTART = 3'h5;

   reg [2:0]  state;
   reg [2:0]  next_state;
   reg [15:0] t_ms;
   reg [15:0] open_ms;
   reg [15:0] still_ms;
   reg [15:0] cool_ms;
   reg [3:0]  freq_cnt;
   reg        armed;
   reg        freq_fault;
   reg        cur_fault;
   reg        prog_fault;
   reg [31:0] ctrl;
   reg [2:0]  flash_code;
   wire       tick;

   wire apb_acc = psel && penable && !pready;
   wire apb_wr  = psel && penable && pready && pwrite;
   wire braking = (state == S_REMAN) || (state == S_BOUNCE) ||
                  (state == S_BRAKE);

   // Ms from a setting in tenths of a second.
   function [15:0] ds_to_ms;
      input [9:0] ds;
      begin
         ds_to_ms = ds * `DCB_DS_TO_MS;
      end
   endfunction

   // Address decode for the error flag; read data decodes the address itself.
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `DCB_REG_CTRL) || (a == `DCB_REG_STATUS) ||
                  (a == `DCB_REG_SETPT) || (a == `DCB_REG_COUNT);
      end
   endfunction

   // Settings out of range are clamped, never refused, so that a bad
   // write still leaves a unit that brakes.
   wire [9:0] time_max = ctrl[`DCB_CTRL_EXT] ? `DCB_TIME_EXT_DS
                                              : `DCB_TIME_STD_DS;
   wire [9:0] time_raw = ctrl[`DCB_CTRL_TIME_HI:0];
   wire [9:0] time_ds  = (time_raw > time_max) ? time_max : time_raw;
   wire [15:0] time_ms = ds_to_ms(time_ds);
   wire [6:0] pct_raw  = ctrl[`DCB_CTRL_PCT_HI:`DCB_CTRL_PCT_LO];
   wire [6:0] pct_cap  = (time_ds > `DCB_DERATE_DS) ? `DCB_DERATE_PCT
                                                   : `DCB_PCT_MAX;
   wire [6:0] pct_lo   = (pct_raw < `DCB_PCT_MIN) ? `DCB_PCT_MIN : pct_raw;
   wire [6:0] pct      = (pct_lo > pct_cap) ? pct_cap : pct_lo;
   wire       start_ev = armed && start_contact_in && state == S_IDLE;
   // The indicate-only variant reports excess braking but never blocks
   // a start; a controller fault always does.
   wire       lock_out = (freq_fault && !ctrl[`DCB_CTRL_IND]) ||
                         prog_fault;

   dcb_ms_tick
   #(
      .DIV (TICK_DIV)
   )
   u_tick
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .tick    (tick)
   );

   // Next state of the braking sequence.
   always @*
   begin
      next_state = state;
      case (state)
         S_IDLE:
            if (start_ev)
               next_state = S_REMAN;
         S_REMAN:
            if (t_ms >= `DCB_REMAN_MAX_MS ||
                (t_ms >= `DCB_REMAN_MIN_MS && remanence_low))
               next_state = S_BOUNCE;
         S_BOUNCE:
            if (t_ms >= `DCB_BOUNCE_MS)
               next_state = S_BRAKE;
         S_BRAKE:
            if (t_ms >= time_ms && still_ms >= `DCB_STILL_MS)
               next_state = S_IDLE;
            // Without a standstill signal the current still ends at the
            // longest settable time, so a dead sensor cannot hold it on.
            else if (t_ms >= ds_to_ms(`DCB_TIME_EXT_DS) &&
                     t_ms >= time_ms)
               next_state = S_IDLE;
         S_ABORT:
            if (start_contact_in)
               next_state = S_RESTART;
         S_RESTART:
            if (!start_contact_in)
               next_state = S_ABORT;
            else if (t_ms >= `DCB_RESTART_MS)
               next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
      // Abort and a controller fault override every step above; a fault
      // parks the sequence in idle with the contacts locked.
      if (braking && open_ms >= `DCB_ABORT_MS)
         next_state = S_ABORT;
      if (prog_fault)
         next_state = S_IDLE;
   end

   // Sequence state, timers and fault latches.
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state      <= S_IDLE;
         t_ms       <= 16'h0000;
         open_ms    <= 16'h0000;
         still_ms   <= 16'h0000;
         cool_ms    <= 16'h0000;
         freq_cnt   <= 4'h0;
         armed      <= 1'b0;
         freq_fault <= 1'b0;
         cur_fault  <= 1'b0;
         prog_fault <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (next_state != state)
            t_ms <= 16'h0000;
         else if (tick && t_ms != 16'hffff)
            t_ms <= t_ms + 16'h0001;
         // A short opening is contact bounce or chatter and is ignored.
         if (!braking || start_contact_in)
            open_ms <= 16'h0000;
         else if (tick && open_ms != 16'hffff)
            open_ms <= open_ms + 16'h0001;
         if (!motor_standstill || state != S_BRAKE)
            still_ms <= 16'h0000;
         else if (tick && still_ms != 16'hffff)
            still_ms <= still_ms + 16'h0001;
         // Only an opening seen after reset arms the start detector.
         if (!start_contact_in && state == S_IDLE)
            armed <= 1'b1;
         else if (start_ev)
            armed <= 1'b0;
         // Each braking start adds one to the count and every quiet
         // minute takes one away. The sixth start in a row latches the
         // fault, and only a loss of supply, seen as reset, clears it.
         if (start_ev)
         begin
            cool_ms  <= 16'h0000;
            if (freq_cnt != 4'hf)
               freq_cnt <= freq_cnt + 4'h1;
            if (freq_cnt >= `DCB_FREQ_MAX)
               freq_fault <= 1'b1;
            cur_fault <= 1'b0;
         end
         else if (tick)
         begin
            if (cool_ms >= `DCB_COOL_MS)
            begin
               cool_ms <= 16'h0000;
               if (freq_cnt != 4'h0)
                  freq_cnt <= freq_cnt - 4'h1;
            end
            else
               cool_ms <= cool_ms + 16'h0001;
         end
         // Current not reached is judged only when the set time leaves
         // room for the check, so short brakings never report it.
         if (state == S_BRAKE && !current_reached &&
             t_ms >= `DCB_CUR_WAIT_MS && time_ms > `DCB_CUR_WAIT_MS)
            cur_fault <= 1'b1;
         if (controller_fault)
            prog_fault <= 1'b1;
      end
   end

   // Contact outputs and power stage, all registered.
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         interlock_terminal      <= 1'b0;
         star_contactor_terminal <= 1'b0;
         brake_relay             <= 1'b0;
         current_enable          <= 1'b0;
         current_setpoint        <= 7'h00;
         flash_code              <= `DCB_CODE_STEADY;
      end
      else
      begin
         // The interlock opens as the state leaves idle, before the relay
         // can pull in, so the motor contactor is never fed while braking.
         // The restart wait holds both contact paths open.
         interlock_terminal <= !braking && !lock_out &&
                               state == S_IDLE;
         star_contactor_terminal <= braking || state == S_ABORT ||
                                    lock_out;
         brake_relay    <= state == S_BOUNCE || state == S_BRAKE;
         current_enable <= state == S_BRAKE && next_state == S_BRAKE;
         current_setpoint <= pct;
         if (prog_fault)
            flash_code <= `DCB_CODE_PROG;
         else if (freq_fault)
            flash_code <= `DCB_CODE_FREQ;
         else if (cur_fault)
            flash_code <= `DCB_CODE_CURRENT;
         else
            flash_code <= `DCB_CODE_STEADY;
      end
   end

   dcb_flasher u_led_ready
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .tick    (tick),
      .enable  (1'b1),
      .code    (flash_code),
      .led     (led_ready)
   );

   dcb_flasher u_led_current
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .tick    (tick),
      .enable  (current_enable),
      .code    (`DCB_CODE_STEADY),
      .led     (led_current)
   );

   // APB slave: one wait state, then pready for one cycle.
   // A write lands at the edge where pready is seen high; an unmapped
   // address answers with an error and changes nothing. Read data is
   // zero outside the answer cycle, so a stale word never shows.
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl    <= `DCB_CTRL_RESET;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= apb_acc;
         pslverr <= apb_acc && !mapped(paddr);
         if (apb_wr && paddr == `DCB_REG_CTRL)
            ctrl <= pwdata;
         if (apb_acc && !pwrite)
         begin
            case (paddr)
               `DCB_REG_CTRL:
                  prdata <= ctrl;
               `DCB_REG_STATUS:
                  prdata <= {20'h0_0000, current_enable, brake_relay,
                             star_contactor_terminal, interlock_terminal,
                             prog_fault, freq_fault, cur_fault,
                             armed, 1'b0, state};
               `DCB_REG_SETPT:
                  prdata <= {25'h000_0000, current_setpoint};
               `DCB_REG_COUNT:
                  prdata <= {28'h000_0000, freq_cnt};
               default:
                  prdata <= 32'h0000_0000;
            endcase
         end
         else
            prdata <= 32'h0000_0000;
      end
   end
endmodule

// [logic/dcb_consts.vh]
// Purpose: Shared constants of the DC braking sequencer.
// Assumes: 10 MHz reference clock, all timing counted in milliseconds.
// Notes:   Register offsets are byte addresses on the APB slave.
`ifndef DCB_CONSTS_VH
`define DCB_CONSTS_VH
`define DCB_CLK_KHZ       10000
`define DCB_REMAN_MIN_MS  16'h00c8
`define DCB_REMAN_MAX_MS  16'h0708
`define DCB_BOUNCE_MS     16'h0014
`define DCB_ABORT_MS      16'h0096
`define DCB_RESTART_MS    16'h04b0
`define DCB_STILL_MS      16'h07d0
`define DCB_CUR_WAIT_MS   16'h01f4
`define DCB_COOL_MS       16'hea60
`define DCB_FREQ_MAX      4'h5
`define DCB_DS_TO_MS      16'h0064
`define DCB_TIME_STD_DS   10'h12c
`define DCB_TIME_EXT_DS   10'h258
`define DCB_DERATE_DS     10'h0c8
`define DCB_DERATE_PCT    7'h3c
`define DCB_PCT_MIN       7'h0a
`define DCB_PCT_MAX       7'h64
`define DCB_FLASH_ON_MS   12'h0fa
`define DCB_FLASH_OFF_MS  12'h0fa
`define DCB_FLASH_GAP_MS  12'h3e8
`define DCB_CODE_STEADY   3'h0
`define DCB_CODE_CURRENT  3'h2
`define DCB_CODE_FREQ     3'h3
`define DCB_CODE_PROG     3'h4
`define DCB_REG_CTRL      12'h000
`define DCB_REG_STATUS    12'h004
`define DCB_REG_SETPT     12'h008
`define DCB_REG_COUNT     12'h00c
`define DCB_CTRL_RESET    32'h0032_012c
`define DCB_CTRL_TIME_HI  9
`define DCB_CTRL_PCT_LO   16
`define DCB_CTRL_PCT_HI   22
`define DCB_CTRL_EXT      24
`define DCB_CTRL_IND      25
`endif

// [logic/dcb_ms_tick.v]
// Purpose: Common millisecond tick from the reference clock.
// Assumes: DIV reference cycles make one millisecond.
// Notes:   Tick is a one-cycle pulse; shorten DIV in simulation.
`timescale 1ns/1ps
`include "dcb_consts.vh"
module dcb_ms_tick
#(
   parameter DIV = `DCB_CLK_KHZ
)
(
   // Clock and reset
   input  wire ref_clk,
   input  wire nrst,
   // Tick
   output reg  tick
);
   reg [15:0] cnt;

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt  <= 16'h0000;
         tick <= 1'b0;
      end
      else if (cnt == DIV[15:0] - 16'h0001)
      begin
         cnt  <= 16'h0000;
         tick <= 1'b1;
      end
      else
      begin
         cnt  <= cnt + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// [logic/dcb_flasher.v]
// Purpose: Drives an LED steadily or with repeated bursts of flashes.
// Assumes: tick is the common millisecond pulse.
// Notes:   A new code takes effect at once, mid-burst; steady clears the burst.
`timescale 1ns/1ps
`include "dcb_consts.vh"
module dcb_flasher
(
   // Clock and reset
   input  wire       ref_clk,
   input  wire       nrst,
   // Control
   input  wire       tick,
   input  wire       enable,
   input  wire [2:0] code,
   // LED
   output reg        led
);
   reg [11:0] ms;
   reg [2:0]  done;
   reg        lit;

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ms   <= 12'h000;
         done <= 3'h0;
         lit  <= 1'b0;
         led  <= 1'b0;
      end
      else if (code == `DCB_CODE_STEADY)
      begin
         ms   <= 12'h000;
         done <= 3'h0;
         lit  <= 1'b0;
         led  <= enable;
      end
      else
      begin
         // Steady mode may leave the lamp on; it goes dark here so that
         // the first flash of a burst is as long as the others.
         led <= lit;
         if (tick)
         begin
            ms <= ms + 12'h001;
            if (lit && ms >= `DCB_FLASH_ON_MS)
            begin
               lit  <= 1'b0;
               led  <= 1'b0;
               ms   <= 12'h000;
               done <= done + 3'h1;
            end
            else if (!lit && done == code && ms >= `DCB_FLASH_GAP_MS)
            begin
               done <= 3'h0;
               ms   <= 12'h000;
            end
            else if (!lit && done != code && ms >= `DCB_FLASH_OFF_MS)
            begin
               lit <= 1'b1;
               led <= 1'b1;
               ms  <= 12'h000;
            end
         end
      end
   end
endmodule

// [dv/dcb_sequencer_sva.sv]
// Purpose: Port assertions for the DC braking sequencer.
// Assumes: TICK_DIV equals the bound instance value.
// Notes:   Bounds allow one millisecond of tick jitter.
`timescale 1ns/1ps
module dcb_sequencer_sva
#(
   parameter TICK_DIV = 10
)
(
   // Clock and reset
   input wire       ref_clk,
   input wire       nrst,
   // Watched ports
   input wire       start_contact_in,
   input wire       interlock_terminal,
   input wire       star_contactor_terminal,
   input wire       brake_relay,
   input wire       current_enable,
   input wire [6:0] current_setpoint,
   input wire       led_current
);
   reg [31:0] brk_cnt;
   reg [31:0] rly_cnt;
   reg [31:0] rst_cnt;
   wire       braking;
   wire       waiting;
   assign braking = !interlock_terminal && star_contactor_terminal;
   assign waiting = !interlock_terminal && !star_contactor_terminal;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Cycle counts let long waits be checked without long repetitions.
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         brk_cnt <= 32'h0;
         rly_cnt <= 32'h0;
         rst_cnt <= 32'h0;
      end
      else
      begin
         brk_cnt <= braking ? brk_cnt + 32'h1 : 32'h0;
         rly_cnt <= brake_relay ? rly_cnt + 32'h1 : 32'h0;
         // Only a wait that follows braking or abort is timed; the open
         // pair right after reset is no restart.
         rst_cnt <= (waiting && (rst_cnt != 32'h0 || brk_cnt != 32'h0)) ?
                    rst_cnt + 32'h1 : 32'h0;
      end
   end
   AST_RELAY_LOCKS: assert property (
      brake_relay |-> !interlock_terminal)
      else $error("interlock closed while relay on");
   AST_STAR_CLOSED: assert property (
      current_enable |-> star_contactor_terminal)
      else $error("star path open while current flows");
   AST_START: assert property (
      $rose(start_contact_in) && interlock_terminal
      |-> ##2 !interlock_terminal && star_contactor_terminal)
      else $error("reclosure did not start braking");
   AST_REMANENCE: assert property (
      $rose(brake_relay) |-> brk_cnt >= 199 * TICK_DIV
      && brk_cnt <= 1801 * TICK_DIV)
      else $error("relay outside remanence window");
   AST_BOUNCE: assert property (
      $rose(current_enable) |-> rly_cnt >= 19 * TICK_DIV)
      else $error("current before bounce time");
   AST_LED_CURRENT: assert property (
      $changed(current_enable) |=> led_current == $past(current_enable))
      else $error("current indicator does not follow current");
   AST_SETPOINT: assert property (
      current_enable |-> current_setpoint >= 7'h0a
      && current_setpoint <= 7'h64)
      else $error("setpoint out of range");
   AST_RESTART: assert property (
      $rose(interlock_terminal) |-> rst_cnt == 0
      || rst_cnt >= 1199 * TICK_DIV)
      else $error("restart released early");
endmodule

// [dv/dcb_motor_model.sv]
// Purpose: Contactor circuit and operator beside the braking unit.
// Assumes: MS cycles make one millisecond.
// Notes:   Motor sensors are crude time models after stop.
`timescale 1ns/1ps
module dcb_motor_model
#(
   parameter MS = 10
)
(
   // Clock and reset
   input  wire ref_clk,
   input  wire nrst,
   // Operator
   input  wire run_req,
   input  wire intr_req,
   // From the device
   input  wire interlock_terminal,
   input  wire current_enable,
   // To the device
   output wire start_contact_in,
   output wire motor_standstill,
   output wire remanence_low,
   output wire current_reached
);
   reg        running;
   reg [31:0] stop_cnt;
   reg [31:0] intr_cnt;
   // The coil is fed through the interlock path, so no restart can
   // happen while the device holds that path open.
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         running  <= 1'b0;
         stop_cnt <= 32'h0;
         intr_cnt <= 32'h0;
      end
      else
      begin
         running  <= run_req && interlock_terminal;
         stop_cnt <= running ? 32'h0 : stop_cnt + 32'h1;
         if (intr_req)
            intr_cnt <= 200 * MS;
         else if (intr_cnt != 32'h0)
            intr_cnt <= intr_cnt - 32'h1;
      end
   end
   assign start_contact_in = !running && intr_cnt == 32'h0;
   assign motor_standstill = stop_cnt > 100 * MS;
   assign remanence_low    = stop_cnt > 250 * MS;
   assign current_reached  = current_enable;
endmodule

// [dv/dcb_sequencer_tb.sv]
// Purpose: Self-checking bench of the DC braking sequencer.
// Assumes: TICK_DIV of 10, so one millisecond is ten cycles.
// Notes:   APB read results are compared from a queue by a monitor.
`timescale 1ns/1ps
`include "dcb_consts.vh"
module dcb_sequencer_tb;
   localparam TD = 10;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic        controller_fault = 1'b0;
   logic        run_req = 1'b0;
   logic        intr_req = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, start_contact_in, remanence_low;
   logic        motor_standstill, current_reached, interlock_terminal;
   logic        star_contactor_terminal, brake_relay, current_enable;
   logic        led_ready, led_current;
   logic [6:0]  current_setpoint, rp;
   logic [6:0]  pct [4];
   logic [6:0]  ex [4];
   logic [9:0]  tm [4];
   logic [32:0] exp_q [$];
   logic [32:0] note;
   int          failures = 0;
   int          samples_checked = 0;
   int          n, i;

   always #50 ref_clk = ~ref_clk;

   dcb_sequencer #(.TICK_DIV(TD)) dcb_sequencer_i
      (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
       .prdata, .pready, .pslverr, .start_contact_in, .remanence_low,
       .motor_standstill, .current_reached, .controller_fault,
       .interlock_terminal, .star_contactor_terminal, .brake_relay,
       .current_enable, .current_setpoint, .led_ready, .led_current);
   dcb_motor_model #(.MS(TD)) dcb_motor_model_i
      (.ref_clk, .nrst, .run_req, .intr_req, .interlock_terminal,
       .current_enable, .start_contact_in, .motor_standstill,
       .remanence_low, .current_reached);

   task results;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string w, input logic [31:0] s,
                        input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", w, e, s);
      end
   endtask

   // Bounded wait on a level; the count lands in n.
   task automatic wait_sig(ref logic s, input logic v, input int lim);
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (s !== v && n < lim);
      if (s !== v)
      begin
         check("wait", 32'h0, 32'h1);
         results();
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      wait_sig(pready, 1'b1, 20);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic apb_rd(input logic [11:0] a, input logic [31:0] d,
                         input logic e);
      exp_q.push_back({e, d});
      apb(1'b0, a, 32'h0);
   endtask

   task start_brake;
      run_req <= 1'b1;
      wait_sig(start_contact_in, 1'b0, 100);
      repeat (100 * TD) @(posedge ref_clk);
      run_req <= 1'b0;
      wait_sig(interlock_terminal, 1'b0, 100);
   endtask

   always @(posedge ref_clk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         note = exp_q.pop_front();
         check("prdata", prdata, note[31:0]);
         check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      end
   end

   initial
   begin
      rp = $urandom(32'hf0ad);
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (50 * TD) @(posedge ref_clk);
      check("interlock", interlock_terminal, 1'b1);
      check("star", star_contactor_terminal, 1'b0);
      check("ready led", led_ready, 1'b1);
      $display("test powerup done");
      apb_rd(`DCB_REG_CTRL, `DCB_CTRL_RESET, 1'b0);
      apb_rd(12'h010, 32'h0, 1'b1);
      pct = '{7'h64, 7'h64, 7'h05, rp};
      tm  = '{10'h005, 10'h0fa, 10'h005, 10'h005};
      ex  = '{7'h64, `DCB_DERATE_PCT, `DCB_PCT_MIN, (rp < 7'h0a) ?
             `DCB_PCT_MIN : (rp > 7'h64) ? `DCB_PCT_MAX : rp};
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, `DCB_REG_CTRL, {9'h0, pct[i], 6'h0, tm[i]});
         apb_rd(`DCB_REG_SETPT, {25'h0, ex[i]}, 1'b0);
      end
      apb(1'b1, `DCB_REG_CTRL, 32'h0064_0005);
      apb_rd(`DCB_REG_CTRL, 32'h0064_0005, 1'b0);
      $display("test registers done");
      start_brake;
      check("star", star_contactor_terminal, 1'b1);
      wait_sig(brake_relay, 1'b1, 2000 * TD);
      check("remanence", n >= 199 * TD, 1'b1);
      wait_sig(current_enable, 1'b1, 30 * TD);
      check("bounce", n >= 19 * TD, 1'b1);
      check("setpoint", current_setpoint, 7'h64);
      @(posedge ref_clk);
      check("current led", led_current, 1'b1);
      wait_sig(current_enable, 1'b0, 3000 * TD);
      check("stop delay", n >= 1800 * TD, 1'b1);
      check("interlock", interlock_terminal, 1'b0);
      repeat (2) @(posedge ref_clk);
      check("interlock", interlock_terminal, 1'b1);
      check("star", star_contactor_terminal, 1'b0);
      check("current led", led_current, 1'b0);
      $display("test braking done");
      start_brake;
      wait_sig(current_enable, 1'b1, 400 * TD);
      intr_req <= 1'b1;
      @(posedge ref_clk);
      intr_req <= 1'b0;
      repeat (170 * TD) @(posedge ref_clk);
      check("relay", brake_relay, 1'b0);
      check("current", current_enable, 1'b0);
      check("interlock", interlock_terminal, 1'b0);
      check("star", star_contactor_terminal, 1'b1);
      wait_sig(star_contactor_terminal, 1'b0, 100 * TD);
      wait_sig(interlock_terminal, 1'b1, 1300 * TD);
      check("restart", n >= 1199 * TD, 1'b1);
      $display("test abort done");
      controller_fault <= 1'b1;
      wait_sig(interlock_terminal, 1'b0, 10);
      check("star", star_contactor_terminal, 1'b1);
      wait_sig(led_ready, 1'b0, 10);
      wait_sig(led_ready, 1'b1, 300 * TD);
      check("flash off", n >= 249 * TD, 1'b1);
      for (i = 0; i < 3; i++)
      begin
         wait_sig(led_ready, 1'b0, 300 * TD);
         wait_sig(led_ready, 1'b1, 300 * TD);
      end
      wait_sig(led_ready, 1'b0, 300 * TD);
      wait_sig(led_ready, 1'b1, 1300 * TD);
      check("flash gap", n >= 1000 * TD, 1'b1);
      $display("test fault done");
      results();
   end
endmodule

bind dcb_sequencer dcb_sequencer_sva #(.TICK_DIV(TICK_DIV))
   dcb_sequencer_sva_i
   (.ref_clk, .nrst, .start_contact_in, .interlock_terminal,
    .star_contactor_terminal, .brake_relay, .current_enable,
    .current_setpoint, .led_current);
